// ---- rtl/dso_pkg.sv ----
// shared types and constants of the adder/output stage
package dso_pkg;
  localparam int OPW   = 18;
  localparam int ACW   = 52;
  localparam int LANES = 4;
  localparam int NPROD = 8;
  localparam int AXW   = 4;
  localparam int DW    = 32;
  localparam logic [AXW-1:0] CTRL_OFS    = 4'h0;
  localparam logic [AXW-1:0] STAT_OFS    = 4'h4;
  localparam logic [1:0]     RESP_OKAY   = 2'h0;
  localparam logic [1:0]     RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MD_SIMPLE = 2'h0,
    MD_MAC    = 2'h1,
    MD_ADD2   = 2'h2,
    MD_ADD4   = 2'h3
  } dso_mode_t;

  typedef enum logic [1:0] {
    SZ_9  = 2'h0,
    SZ_18 = 2'h1,
    SZ_36 = 2'h2
  } dso_size_t;

  // control register, msb first
  typedef struct packed {
    logic [1:0] sload_dly;
    logic [1:0] addsub_dly;
    logic [1:0] sign_dly;
    logic [1:0] out_set;
    logic [2:0] rsvd;
    logic       outreg_en;
    dso_size_t  size;
    dso_mode_t  mode;
  } dso_cfg_t;

  localparam logic [15:0] CFG_RST = 16'h0004;

  // status register, msb first
  typedef struct packed {
    logic [9:0] rsvd;
    logic [1:0] ovf;
    dso_size_t  size;
    dso_mode_t  mode;
  } dso_stat_t;

  typedef struct packed {
    logic [LANES-1:0][OPW-1:0] a;
    logic [LANES-1:0][OPW-1:0] b;
  } dso_ops_t;

  typedef struct packed {
    logic       sign_a;
    logic       sign_b;
    logic [1:0] addnsub;
    logic [1:0] sload;
  } dso_ctl_t;

  typedef logic [LANES-1:0][ACW-1:0] dso_lanes_t;

  typedef struct packed {
    dso_ops_t             ops;
    logic [1:0][ACW-1:0]  acc;
    dso_lanes_t           oreg;
    dso_lanes_t           res;
    logic [1:0]           ovf;
  } dso_st_t;

  typedef struct packed {
    logic           aw_ok;
    logic           w_ok;
    logic [AXW-1:0] awaddr;
    logic [DW-1:0]  wdata;
    logic [3:0]     wstrb;
    logic           aw_rdy;
    logic           w_rdy;
    logic           ar_rdy;
    logic           bv;
    logic [1:0]     bresp;
    logic           rv;
    logic [DW-1:0]  rdata;
    logic [1:0]     rresp;
    dso_cfg_t       cfg;
  } dso_bus_t;
endpackage : dso_pkg

// ---- rtl/dso_dly.sv ----
// selectable zero, one or two stage delay for control inputs
`timescale 1ns/100ps
module dso_dly #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  input  wire logic [1:0]   depth_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dso_dly_t;
  dso_dly_t st_q;
  dso_dly_t st_d;

  // shift the chain and tap it at the chosen depth
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d_i;
    st_d.s2 = st_q.s1;
    case (depth_i)
      2'h0:    q_o = d_i;
      2'h1:    q_o = st_q.s1;
      default: q_o = st_q.s2;
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) st_q <= '0;
    else         st_q <= st_d;
  end
endmodule : dso_dly

// ---- rtl/dso_axil.sv ----
// axi4-lite slave holding the control and status registers
`timescale 1ns/100ps
module dso_axil (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic [dso_pkg::AXW-1:0] awaddr_i,
  input  wire logic                    awvalid_i,
  output logic                         awready_o,
  input  wire logic [dso_pkg::DW-1:0]  wdata_i,
  input  wire logic [3:0]              wstrb_i,
  input  wire logic                    wvalid_i,
  output logic                         wready_o,
  output logic [1:0]                   bresp_o,
  output logic                         bvalid_o,
  input  wire logic                    bready_i,
  input  wire logic [dso_pkg::AXW-1:0] araddr_i,
  input  wire logic                    arvalid_i,
  output logic                         arready_o,
  output logic [dso_pkg::DW-1:0]       rdata_o,
  output logic [1:0]                   rresp_o,
  output logic                         rvalid_o,
  input  wire logic                    rready_i,
  input  wire dso_pkg::dso_stat_t      stat_i,
  output dso_pkg::dso_cfg_t            cfg_o
);
  dso_pkg::dso_bus_t st_q;
  dso_pkg::dso_bus_t st_d;
  logic [15:0]       cw;

  // capture address and data apart, write once both are held
  always_comb begin
    st_d = st_q;
    cw   = st_q.cfg;
    if (bready_i && st_q.bv) st_d.bv = 1'b0;
    if (rready_i && st_q.rv) st_d.rv = 1'b0;
    if (awvalid_i && st_q.aw_rdy) begin
      st_d.aw_ok  = 1'b1;
      st_d.awaddr = awaddr_i;
    end
    if (wvalid_i && st_q.w_rdy) begin
      st_d.w_ok  = 1'b1;
      st_d.wdata = wdata_i;
      st_d.wstrb = wstrb_i;
    end
    if (st_d.aw_ok && st_d.w_ok && !st_d.bv) begin
      st_d.aw_ok = 1'b0;
      st_d.w_ok  = 1'b0;
      st_d.bv    = 1'b1;
      st_d.bresp = dso_pkg::RESP_OKAY;
      if (st_d.awaddr == dso_pkg::CTRL_OFS) begin
        if (st_d.wstrb[0]) cw[7:0] = st_d.wdata[7:0];
        if (st_d.wstrb[1]) cw[15:8] = st_d.wdata[15:8];
        st_d.cfg      = dso_pkg::dso_cfg_t'(cw);
        st_d.cfg.rsvd = 3'h0;
      end else if (st_d.awaddr != dso_pkg::STAT_OFS) begin
        st_d.bresp = dso_pkg::RESP_SLVERR;
      end
    end
    if (arvalid_i && st_q.ar_rdy) begin
      st_d.rv    = 1'b1;
      st_d.rresp = dso_pkg::RESP_OKAY;
      st_d.rdata = '0;
      if (araddr_i == dso_pkg::CTRL_OFS) st_d.rdata[15:0] = st_q.cfg;
      else if (araddr_i == dso_pkg::STAT_OFS) st_d.rdata[15:0] = stat_i;
      else st_d.rresp = dso_pkg::RESP_SLVERR;
    end
    st_d.aw_rdy = !st_d.aw_ok && !st_d.bv;
    st_d.w_rdy  = !st_d.w_ok && !st_d.bv;
    st_d.ar_rdy = !st_d.rv;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q     <= '0;
      st_q.cfg <= dso_pkg::dso_cfg_t'(dso_pkg::CFG_RST);
    end else begin
      st_q <= st_d;
    end
  end

  assign awready_o = st_q.aw_rdy;
  assign wready_o  = st_q.w_rdy;
  assign bvalid_o  = st_q.bv;
  assign bresp_o   = st_q.bresp;
  assign arready_o = st_q.ar_rdy;
  assign rvalid_o  = st_q.rv;
  assign rdata_o   = st_q.rdata;
  assign rresp_o   = st_q.rresp;
  assign cfg_o     = st_q.cfg;
endmodule : dso_axil

// ---- rtl/dso_top.sv ----
// adder/output stage: products, adders, accumulators, summation, output mux
// Contract
// - accumulator mode always uses output registers
// - adders take only internal multiplier products
// - add_not_sub high adds, low subtracts
// - two controls; 9x9 split top/bottom pairs
// - add/sub control delay zero, one, two
// - shared sign controls, up to two stages
// - sync load puts product into accumulator
// - overflow flag registered, not held
// - summation adds four products per unit
// - output mux picks product, adder, or sum
// - output registers use one of four sets
// - one mode per block, no mixing
// - simple mode passes products straight out
// - 36x36 built from four 18x18 products
// - accumulators fed by second, fourth multipliers
// - accumulator is 52 bits wide
// - load and overflow only in accumulate
// - two-multiplier adder gives pair sums
// - complex product via one subtract, one add
// - four-multiplier adder sums two adders
// - four-tap filter via four-multiplier sum
// - sign high signed, low unsigned
`timescale 1ns/100ps
module dso_top (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic [dso_pkg::AXW-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [dso_pkg::DW-1:0]  s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [dso_pkg::AXW-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [dso_pkg::DW-1:0]       s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire dso_pkg::dso_ops_t       ops_i,
  input  wire dso_pkg::dso_ctl_t       ctl_i,
  input  wire logic [3:0]              ena_i,
  input  wire logic [3:0]              clr_i,
  output dso_pkg::dso_lanes_t          res_o,
  output logic [1:0]                   ovf_o
);
  localparam int OPW = dso_pkg::OPW;
  localparam int ACW = dso_pkg::ACW;
  localparam int HW  = OPW / 2;

  dso_pkg::dso_st_t    st_q;
  dso_pkg::dso_st_t    st_d;
  dso_pkg::dso_cfg_t   cfg;
  dso_pkg::dso_stat_t  stat;
  dso_pkg::dso_mode_t  mode_e;
  logic [1:0]          sgn_d;
  logic [1:0]          as_d;
  logic [1:0]          sl_d;
  logic [ACW-1:0]      prod [dso_pkg::NPROD];
  logic [ACW-1:0]      fa   [4];
  logic [ACW-1:0]      sm   [2];
  logic [ACW-1:0]      macp [2];
  logic [ACW:0]        stp  [2];
  logic [2*ACW-33:0]   p72;
  dso_pkg::dso_lanes_t mx;
  logic                sa;
  logic                sb;
  logic                sel_en;
  logic                sel_clr;
  logic                mac;
  logic                oreg_use;

  // operand multiply with sign-marked operands
  function automatic logic [ACW-1:0] mulx(input logic [OPW-1:0] x, input logic [OPW-1:0] y,
                                          input logic xs, input logic ys);
    logic signed [OPW:0]     sx;
    logic signed [OPW:0]     sy;
    logic signed [2*OPW+1:0] p;
    sx   = $signed({xs & x[OPW-1], x});
    sy   = $signed({ys & y[OPW-1], y});
    p    = sx * sy;
    mulx = {{(ACW-2*OPW-2){p[2*OPW+1]}}, p};
  endfunction : mulx

  // widen a half-width operand to full width
  function automatic logic [OPW-1:0] ext9(input logic [HW-1:0] x, input logic s);
    ext9 = {{(OPW-HW){s & x[HW-1]}}, x};
  endfunction : ext9

  // sign-extend a product to the 72-bit 36x36 result
  function automatic logic [2*ACW-33:0] sx72(input logic [ACW-1:0] x);
    sx72 = {{(ACW-32){x[ACW-1]}}, x};
  endfunction : sx72

  // one accumulator step, top bit is overflow or underflow
  function automatic logic [ACW:0] step(input logic [ACW-1:0] acc, input logic [ACW-1:0] p,
                                        input logic add, input logic sgn);
    logic [ACW:0] r;
    logic         ov;
    r = add ? ({1'b0, acc} + {1'b0, p}) : ({1'b0, acc} - {1'b0, p});
    if (sgn) begin
      ov = (add ? (acc[ACW-1] == p[ACW-1]) : (acc[ACW-1] != p[ACW-1]))
           && (r[ACW-1] != acc[ACW-1]);
    end else begin
      ov = r[ACW];
    end
    step = {ov, r[ACW-1:0]};
  endfunction : step

  // register bus slave
  dso_axil u_bus (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .awaddr_i  (s_axi_awaddr),
    .awvalid_i (s_axi_awvalid),
    .awready_o (s_axi_awready),
    .wdata_i   (s_axi_wdata),
    .wstrb_i   (s_axi_wstrb),
    .wvalid_i  (s_axi_wvalid),
    .wready_o  (s_axi_wready),
    .bresp_o   (s_axi_bresp),
    .bvalid_o  (s_axi_bvalid),
    .bready_i  (s_axi_bready),
    .araddr_i  (s_axi_araddr),
    .arvalid_i (s_axi_arvalid),
    .arready_o (s_axi_arready),
    .rdata_o   (s_axi_rdata),
    .rresp_o   (s_axi_rresp),
    .rvalid_o  (s_axi_rvalid),
    .rready_i  (s_axi_rready),
    .stat_i    (stat),
    .cfg_o     (cfg)
  );

  // status view of the running block
  always_comb begin
    stat      = '0;
    stat.mode = mode_e;
    stat.size = cfg.size;
    stat.ovf  = st_q.ovf;
  end

  // sign controls, same pins as the multipliers, 0..2 stages
  dso_dly #(.W(2)) u_sgn (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .d_i     ({ctl_i.sign_b, ctl_i.sign_a}),
    .depth_i (cfg.sign_dly),
    .q_o     (sgn_d)
  );

  // add/sub controls aligned to the data pipeline
  dso_dly #(.W(2)) u_as (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .d_i     (ctl_i.addnsub),
    .depth_i (cfg.addsub_dly),
    .q_o     (as_d)
  );

  // accumulator loads, 0..2 stages
  dso_dly #(.W(2)) u_sl (
    .clk_i   (clk_i),
    .nrst_i  (nrst_i),
    .d_i     (ctl_i.sload),
    .depth_i (cfg.sload_dly),
    .q_o     (sl_d)
  );

  // whole datapath and next state
  always_comb begin
    st_d = st_q;
    st_d.ops = ops_i;
    sa = sgn_d[0];
    sb = sgn_d[1];
    // a 36x36 setup always runs as a plain multiplier
    mode_e = (cfg.size == dso_pkg::SZ_36) ? dso_pkg::MD_SIMPLE : cfg.mode;
    mac = (mode_e == dso_pkg::MD_MAC);
    sel_en = ena_i[cfg.out_set];
    sel_clr = clr_i[cfg.out_set];
    oreg_use = mac || cfg.outreg_en;
    // products of the multiplier sub-blocks, the only adder source
    for (int k = 0; k < dso_pkg::NPROD; k++) begin
      prod[k] = '0;
    end
    for (int k = 0; k < dso_pkg::LANES; k++) begin
      if (cfg.size == dso_pkg::SZ_9) begin
        prod[2*k]   = mulx(ext9(st_q.ops.a[k][HW-1:0], sa), ext9(st_q.ops.b[k][HW-1:0], sb), sa, sb);
        prod[2*k+1] = mulx(ext9(st_q.ops.a[k][OPW-1:HW], sa), ext9(st_q.ops.b[k][OPW-1:HW], sb), sa, sb);
      end else begin
        prod[k] = mulx(st_q.ops.a[k], st_q.ops.b[k], sa, sb);
      end
    end
    // 36x36 from four partial products and shifts
    p72 = sx72(mulx(st_q.ops.a[0], st_q.ops.b[0], 1'b0, 1'b0))
        + (sx72(mulx(st_q.ops.a[1], st_q.ops.b[0], sa, 1'b0)) << OPW)
        + (sx72(mulx(st_q.ops.a[0], st_q.ops.b[1], 1'b0, sb)) << OPW)
        + (sx72(mulx(st_q.ops.a[1], st_q.ops.b[1], sa, sb)) << (2 * OPW));
    // first-level adder/subtractors over product pairs
    for (int k = 0; k < 4; k++) begin
      logic sel;
      sel = (cfg.size == dso_pkg::SZ_9) ? as_d[k/2] : as_d[k%2];
      fa[k] = sel ? (prod[2*k] + prod[2*k+1]) : (prod[2*k] - prod[2*k+1]);
    end
    // summation units over two adder outputs
    for (int j = 0; j < 2; j++) begin
      sm[j] = fa[2*j] + fa[2*j+1];
    end
    // accumulator inputs: second and fourth multipliers only
    for (int j = 0; j < 2; j++) begin
      macp[j] = (cfg.size == dso_pkg::SZ_9) ? prod[4*j+2] : prod[2*j+1];
      stp[j] = step(st_q.acc[j], macp[j], as_d[j], sa | sb);
    end
    // output selection
    mx = '0;
    case (mode_e)
      dso_pkg::MD_SIMPLE: begin
        for (int k = 0; k < dso_pkg::LANES; k++) begin
          if (cfg.size == dso_pkg::SZ_9) begin
            mx[k] = {{(ACW-2*OPW){1'b0}}, prod[2*k+1][OPW-1:0], prod[2*k][OPW-1:0]};
          end else begin
            mx[k] = prod[k];
          end
        end
        if (cfg.size == dso_pkg::SZ_36) begin
          mx    = '0;
          mx[0] = {{(ACW-2*OPW){1'b0}}, p72[2*OPW-1:0]};
          mx[1] = {{(ACW-2*OPW){1'b0}}, p72[4*OPW-1:2*OPW]};
        end
      end
      dso_pkg::MD_ADD2: begin
        for (int k = 0; k < 4; k++) begin
          mx[k] = fa[k];
        end
      end
      dso_pkg::MD_ADD4: begin
        mx[0] = sm[0];
        mx[1] = sm[1];
      end
      default: begin
        mx = '0;
      end
    endcase
    // accumulators, held in the selected output register set
    st_d.ovf = 2'h0;
    if (mac) begin
      if (sel_clr) begin
        st_d.acc = '0;
      end else if (sel_en) begin
        for (int j = 0; j < 2; j++) begin
          if (sl_d[j]) begin
            st_d.acc[j] = macp[j];
          end else begin
            st_d.acc[j] = stp[j][ACW-1:0];
            st_d.ovf[j] = stp[j][ACW];
          end
        end
      end
      mx    = '0;
      mx[0] = st_d.acc[0];
      mx[1] = st_d.acc[1];
    end
    // optional output register on the selected set
    if (sel_clr) begin
      st_d.oreg = '0;
    end else if (sel_en) begin
      st_d.oreg = mx;
    end
    st_d.res = (oreg_use && !mac) ? st_q.oreg : mx;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) st_q <= '0;
    else         st_q <= st_d;
  end

  assign res_o = st_q.res;
  assign ovf_o = st_q.ovf;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // accumulator outputs hold without enable or clear
  AST_MAC_HOLD: assert property (mac && !sel_en && !sel_clr && $stable(cfg) |=> $stable(res_o))
    else $error("accumulator output moved without enable");

  // 18x18 pair adder follows its control
  AST_ADD_SUB: assert property (mode_e == dso_pkg::MD_ADD2 && cfg.size == dso_pkg::SZ_18
                                && !cfg.outreg_en
                                |=> res_o[0] == ($past(as_d[0]) ? $past(prod[0] + prod[1])
                                                                : $past(prod[0] - prod[1])))
    else $error("pair adder result wrong");

  // 9x9 second pair uses the first control, as_d[0]
  AST_NINE_SEL: assert property (mode_e == dso_pkg::MD_ADD2 && cfg.size == dso_pkg::SZ_9
                                 && !cfg.outreg_en
                                 |=> res_o[1] == ($past(as_d[0]) ? $past(prod[2] + prod[3])
                                                                 : $past(prod[2] - prod[3])))
    else $error("9x9 top adder control wrong");

  // load replaces the accumulator with the product
  AST_LOAD: assert property (mac && sel_en && !sel_clr && sl_d[0] |=> res_o[0] == $past(macp[0]))
    else $error("accumulator load failed");

  // accumulating step adds or subtracts the product
  AST_ACC: assert property (mac && sel_en && !sel_clr && !sl_d[1]
                            |=> res_o[1] == ($past(as_d[1]) ? $past(st_q.acc[1] + macp[1])
                                                            : $past(st_q.acc[1] - macp[1])))
    else $error("accumulator step wrong");

  // overflow stays low outside accumulate mode, two cycles on
  AST_OVF_MODE: assert property (!mac ##1 !mac |-> ovf_o == 2'h0)
    else $error("overflow outside accumulate mode");

  // summation unit adds both adder results
  AST_SUM: assert property (mode_e == dso_pkg::MD_ADD4 && !cfg.outreg_en
                            |=> res_o[0] == $past(fa[0] + fa[1]))
    else $error("summation result wrong");

  // plain products pass through in simple mode
  AST_SIMPLE: assert property (mode_e == dso_pkg::MD_SIMPLE && cfg.size == dso_pkg::SZ_18
                               && !cfg.outreg_en |=> res_o[2] == $past(prod[2]))
    else $error("simple product not passed");

  // clear of the selected set empties the output register, and the accumulator output at once
  AST_CLR: assert property (sel_clr |=> st_q.oreg == '0 && (!$past(mac) || res_o == '0))
    else $error("output clear ignored");

  // unsigned subtract of a larger product flags underflow
  AST_OVF_SET: assert property (mac && sel_en && !sel_clr && !sl_d[0] && !as_d[0] && !sa && !sb
                                && (macp[0] > st_q.acc[0]) |=> ovf_o[0])
    else $error("accumulator underflow not flagged");
endmodule : dso_top

// ---- tb/dso_fabric.sv ----
// fabric model driving operands and controls into the stage
`timescale 1ns/100ps
module dso_fabric (
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire dso_pkg::dso_ops_t  ops_i,
  input  wire dso_pkg::dso_ctl_t  ctl_i,
  input  wire logic [3:0]         ena_i,
  input  wire logic [3:0]         clr_i,
  input  wire logic [1:0]         ovf_i,
  output dso_pkg::dso_ops_t       ops_o,
  output dso_pkg::dso_ctl_t       ctl_o,
  output logic [3:0]              ena_o,
  output logic [3:0]              clr_o,
  output logic [1:0]              ovf_seen_o
);
  // launch from one clock; one sign source feeds all users
  // all four lanes share one operand width
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ops_o      <= '0;
      ctl_o      <= '0;
      ena_o      <= 4'h0;
      clr_o      <= 4'h0;
      ovf_seen_o <= 2'h0;
    end else begin
      ops_o      <= ops_i;
      ctl_o      <= ctl_i;
      ena_o      <= ena_i;
      clr_o      <= clr_i;
      ovf_seen_o <= ovf_seen_o | ovf_i; // sticky copy of pulse
    end
  end
endmodule : dso_fabric

// ---- tb/test_dso_top.sv ----
// testbench of the adder/output stage
`timescale 1ns/100ps
module test_dso_top;
  logic                  clk_i = 1'b0;
  logic                  nrst_i = 1'b0;
  logic [3:0]            awaddr = 4'h0;
  logic [3:0]            araddr = 4'h0;
  logic [31:0]           wdata = 32'h0;
  logic                  awvalid = 1'b0;
  logic                  wvalid = 1'b0;
  logic                  bready = 1'b0;
  logic                  arvalid = 1'b0;
  logic                  rready = 1'b0;
  logic                  awready, wready, bvalid, arready, rvalid;
  logic [1:0]            bresp, rresp, ovf, ovf_seen;
  logic [31:0]           rdata;
  dso_pkg::dso_ops_t     ops = '0;
  dso_pkg::dso_ops_t     ops_f;
  dso_pkg::dso_ctl_t     ctl = '0;
  dso_pkg::dso_ctl_t     ctl_f;
  logic [3:0]            ena = 4'h0;
  logic [3:0]            clr = 4'h0;
  logic [3:0]            ena_f, clr_f;
  dso_pkg::dso_lanes_t   res;
  int                    failures = 0;
  int                    check_count = 0;
  int                    cyc = 0;

  always #50 clk_i = ~clk_i;

  dso_fabric i_dso_fabric (.clk_i(clk_i), .nrst_i(nrst_i), .ops_i(ops), .ctl_i(ctl), .ena_i(ena),
    .clr_i(clr), .ovf_i(ovf), .ops_o(ops_f), .ctl_o(ctl_f), .ena_o(ena_f), .clr_o(clr_f),
    .ovf_seen_o(ovf_seen));

  dso_top i_dso_top (.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ops_i(ops_f),
    .ctl_i(ctl_f), .ena_i(ena_f), .clr_i(clr_f), .res_o(res), .ovf_o(ovf));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [51:0] exp, input logic [51:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bit a_ok;
    bit w_ok;
    a_ok = 0;
    w_ok = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a_ok && w_ok)) begin
      @(posedge clk_i);
      if (awready === 1'b1) a_ok = 1;
      if (wready === 1'b1) w_ok = 1;
      if (a_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 52'(dso_pkg::RESP_OKAY), 52'(bresp));
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_i);
    rready <= 1'b0;
    chk("rdata", 52'(ed), 52'(rdata));
    chk("rresp", 52'(er), 52'(rresp));
    @(posedge clk_i);
  endtask : rd

  // let operands and controls settle through the pipeline
  task automatic run(input int n);
    repeat (n) @(posedge clk_i);
  endtask : run

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask : done

  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    run(2);
    rd(dso_pkg::CTRL_OFS, 32'h0000_0004, dso_pkg::RESP_OKAY);
    rd(4'h8, 32'h0, dso_pkg::RESP_SLVERR);
    done("registers");
    for (int k = 0; k < 4; k++) begin
      ops.a[k] <= 18'(5 - k);
      ops.b[k] <= 18'h3;
    end
    run(6);
    for (int k = 0; k < 4; k++) chk("simple lane", 52'(3 * (5 - k)), res[k]);
    wr(dso_pkg::CTRL_OFS, 32'h0000_0006);
    ctl.addnsub <= 2'h1;
    run(6);
    chk("add2 lane0", 52'h1B, res[0]);
    chk("add2 lane1", 52'h3, res[1]);
    ctl.addnsub <= 2'h2;
    run(6);
    chk("add2 lane0", 52'h3, res[0]);
    chk("add2 lane1", 52'hF, res[1]);
    done("adders");
    wr(dso_pkg::CTRL_OFS, 32'h0000_0003);
    for (int k = 0; k < 4; k++) begin
      ops.a[k] <= {9'h2, 9'h1};
      ops.b[k] <= {9'h3, 9'h3};
    end
    ctl.addnsub <= 2'h3;
    run(6);
    chk("sum0", 52'h12, res[0]);
    chk("sum1", 52'h12, res[1]);
    done("summation");
    wr(dso_pkg::CTRL_OFS, 32'h0000_0002);
    ctl.addnsub <= 2'h1;
    run(6);
    chk("add2 nine lane1", 52'h9, res[1]);
    chk("add2 nine lane2", 52'hF_FFFF_FFFF_FFFD, res[2]);
    ctl.addnsub <= 2'h3;
    wr(dso_pkg::CTRL_OFS, 32'h0000_000B);
    ops.a[0] <= 18'h2;
    ops.a[1] <= 18'h1;
    ops.b[0] <= 18'h3;
    ops.b[1] <= 18'h1;
    run(6);
    chk("wide low", 52'h14_0006, res[0]);
    chk("wide high", 52'h1, res[1]);
    done("wide");
    wr(dso_pkg::CTRL_OFS, 32'h0000_0004);
    ops.a[0] <= 18'h3FFFE;
    ctl.sign_a <= 1'b1;
    ctl.sign_b <= 1'b1;
    run(6);
    chk("signed lane0", 52'hF_FFFF_FFFF_FFFA, res[0]);
    ctl.sign_a <= 1'b0;
    ctl.sign_b <= 1'b0;
    wr(dso_pkg::CTRL_OFS, 32'h0000_0014);
    ops.a[0] <= 18'h4;
    ena <= 4'h1;
    clr <= 4'h1;
    run(6);
    chk("cleared lane0", 52'h0, res[0]);
    clr <= 4'h0;
    run(6);
    chk("outreg lane0", 52'hC, res[0]);
    ena <= 4'h0;
    ops.a[0] <= 18'h5;
    run(6);
    chk("held lane0", 52'hC, res[0]);
    done("output register");
    wr(dso_pkg::CTRL_OFS, 32'h0000_0015);
    rd(dso_pkg::CTRL_OFS, 32'h0000_0015, dso_pkg::RESP_OKAY);
    rd(dso_pkg::STAT_OFS, 32'h0000_0005, dso_pkg::RESP_OKAY);
    ops.a[1] <= 18'h5;
    ops.b[1] <= 18'h7;
    ctl.sload <= 2'h3;
    ena <= 4'h1;
    run(3);
    ena <= 4'h0;
    ctl.sload <= 2'h0;
    run(5);
    chk("acc load", 52'd35, res[0]);
    ena <= 4'h1;
    run(3);
    ena <= 4'h0;
    run(5);
    chk("acc add", 52'd140, res[0]);
    ctl.addnsub <= 2'h0;
    ena <= 4'h1;
    run(2);
    ena <= 4'h0;
    run(5);
    chk("acc sub", 52'd70, res[0]);
    chk("overflow seen", 52'h0, 52'(ovf_seen));
    ena <= 4'h1;
    run(3);
    ena <= 4'h0;
    run(5);
    chk("acc under", 52'hF_FFFF_FFFF_FFDD, res[0]);
    chk("overflow seen", 52'h3, 52'(ovf_seen));
    done("accumulator");
    print_verdict();
  end
endmodule : test_dso_top
